// file: hdl/pem_defines.svh
// Purpose: constants for the port E PWM pin function select block
// Assumes: 32-bit classic Wishbone, byte addresses, one word per register
// Notes:   reset values and offsets are fixed here and nowhere else
`ifndef PEM_DEFINES_SVH
`define PEM_DEFINES_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define PEM_OFS_CTRL_L3 8'h00
`define PEM_OFS_CTRL_L4 8'h04
`define PEM_OFS_DIR 8'h08
`define PEM_OFS_DATA 8'h0c
`define PEM_OFS_PIN_LEVEL 8'h10

// ----------------------------------------
// reset values
// ----------------------------------------
`define PEM_CTRL_L3_RST 16'h0000
`define PEM_CTRL_L4_RST 16'h0000
`define PEM_DIR_RST 16'h0000
`define PEM_DATA_RST 16'h0000
`define PEM_RDATA_RST 32'h0000_0000
`define PEM_PIN_SYNC_RST 8'h00
`define PEM_PIN_OUT_RST 8'h00
`define PEM_PIN_OE_RST 8'h00

// ----------------------------------------
// writable bit masks
// ----------------------------------------
`define PEM_CTRL_L3_WMASK 16'h7777
`define PEM_CTRL_L4_WMASK 16'h7737
`define PEM_PORT_WMASK 16'hff00

// ----------------------------------------
// mode field layout and codes
// ----------------------------------------
`define PEM_FIELD_STRIDE 4
`define PEM_FIELD_WIDTH 3
`define PEM_PINS_PER_CTRL 4
`define PEM_FIRST_PIN 8
`define PEM_NUM_PINS 8
`define PEM_MODE_GPIO 3'h0
`define PEM_MODE_TIMER 3'h1
`define PEM_MODE13_TIMER 2'h1
`define PEM_PIN13_IDX 5
`define PEM_PIN10_IDX 2

`endif

// file: hdl/pem_pkg.sv
// Purpose: types shared by the port E PWM pin function select block
// Assumes: constants live in pem_defines.svh
// Notes:   nothing here holds a number of its own
package pem_pkg;

	// ----------------------------------------
	// pin function as decoded from a mode field
	// ----------------------------------------
	typedef enum logic {
		PEM_FUNC_GPIO,
		PEM_FUNC_TIMER
	} pem_func_e;

	// ----------------------------------------
	// drive of one package pin
	// ----------------------------------------
	typedef struct packed {
		logic level;
		logic enable;
	} pem_drive_s;

	// ----------------------------------------
	// timer compare outputs facing this port
	// ----------------------------------------
	typedef struct packed {
		logic t4_d;
		logic t4_c;
		logic t4_b;
		logic t4_a;
		logic t3_d;
		logic t3_b;
		logic t3_a;
	} pem_timer_s;

endpackage : pem_pkg

// file: hdl/pem_port_e_pwm_pin_function_select.sv
// Purpose: function select of port E pins 8 to 15 between GPIO and timer PWM outputs
// Assumes: timer compare outputs come from logic on CORE_CLK; pin levels are asynchronous
// Notes:   pin drive is registered, so a timer edge reaches the pin one cycle later
//          the direction bit gates a pin in timer mode as well
`timescale 1ns/1ps
`default_nettype none
`include "pem_defines.svh"

// Notes on behaviour
// - pin 8 mode 001 carries timer 3 compare output A.
// - pin 9 mode 001 carries timer 3 compare output B.
// - pin 10 mode 000 stays plain general-purpose I/O.
// - pin 11 mode 001 carries timer 3 compare output D.
// - pin 12 mode 001 carries timer 4 compare output A.
// - pin 13 low two mode bits 01 carry timer 4 compare output B.
// - pin 14 mode 001 carries timer 4 compare output C.
// - pin 15 mode 001 carries timer 4 compare output D.
// - direction value fb00 makes the seven PWM pins outputs, pin 10 input.
module pem_port_e_pwm_pin_function_select (
	input wire logic CORE_CLK,
	input wire logic RST_B,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [7:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	input wire logic TIMER3_COMPARE_OUT_A,
	input wire logic TIMER3_COMPARE_OUT_B,
	input wire logic TIMER3_COMPARE_OUT_D,
	input wire logic TIMER4_COMPARE_OUT_A,
	input wire logic TIMER4_COMPARE_OUT_B,
	input wire logic TIMER4_COMPARE_OUT_C,
	input wire logic TIMER4_COMPARE_OUT_D,
	input wire logic [7:0] PORT_PIN_IN,
	output logic [7:0] PORT_PIN_OUT,
	output logic [7:0] PORT_PIN_OE
);

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	// control, direction and data registers
	logic [15:0] ctrl_l3_r;
	logic [15:0] ctrl_l3_nxt;
	logic [15:0] ctrl_l4_r;
	logic [15:0] ctrl_l4_nxt;
	logic [15:0] dir_r;
	logic [15:0] dir_nxt;
	logic [15:0] data_r;
	logic [15:0] data_nxt;

	// bus answer
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic ack_r;
	logic ack_nxt;

	// pin level synchroniser
	logic [7:0] pin_meta_r;
	logic [7:0] pin_meta_nxt;
	logic [7:0] pin_sync_r;
	logic [7:0] pin_sync_nxt;

	// pin drive
	logic [7:0] pin_out_r;
	logic [7:0] pin_out_nxt;
	logic [7:0] pin_oe_r;
	logic [7:0] pin_oe_nxt;

	// bus decode and write strobes
	logic bus_req;
	logic rd_en;
	logic wr_en;
	logic wr_l3;
	logic wr_l4;
	logic wr_dir;
	logic wr_data;
	logic [15:0] wr_lane_mask;
	logic [15:0] wr_val;
	logic [31:0] read_word;
	logic [15:0] pin_level_word;

	// function select
	logic [7:0] timer_vec;
	pem_pkg::pem_timer_s timer_in;
	pem_pkg::pem_func_e pin_func [0:7];
	pem_pkg::pem_drive_s pin_drive [0:7];

	// ----------------------------------------
	// timer bundle
	// ----------------------------------------
	// same clock as the timer, so no synchroniser on these
	// a synchroniser here would add two more cycles of PWM delay
	assign timer_in.t3_a = TIMER3_COMPARE_OUT_A;
	assign timer_in.t3_b = TIMER3_COMPARE_OUT_B;
	assign timer_in.t3_d = TIMER3_COMPARE_OUT_D;
	assign timer_in.t4_a = TIMER4_COMPARE_OUT_A;
	assign timer_in.t4_b = TIMER4_COMPARE_OUT_B;
	assign timer_in.t4_c = TIMER4_COMPARE_OUT_C;
	assign timer_in.t4_d = TIMER4_COMPARE_OUT_D;

	// pin 10 has no timer function on this port
	assign timer_vec = {
		timer_in.t4_d,
		timer_in.t4_c,
		timer_in.t4_b,
		timer_in.t4_a,
		timer_in.t3_d,
		1'b0,
		timer_in.t3_b,
		timer_in.t3_a
	};

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	// one wait state: the request is seen with ack low, ack follows
	assign bus_req = WB_CYC_I && WB_STB_I && !ack_r;
	assign rd_en = bus_req && !WB_WE_I;
	assign wr_en = bus_req && WB_WE_I;
	// sel[3:2] carry no register bits and are ignored
	assign wr_lane_mask = {{8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
	assign wr_val = WB_DAT_I[15:0];

	// ----------------------------------------
	// write strobes
	// ----------------------------------------
	// a write to the pin level word or an unmapped offset raises none of these
	assign wr_l3 = wr_en && (WB_ADR_I == `PEM_OFS_CTRL_L3);
	assign wr_l4 = wr_en && (WB_ADR_I == `PEM_OFS_CTRL_L4);
	assign wr_dir = wr_en && (WB_ADR_I == `PEM_OFS_DIR);
	assign wr_data = wr_en && (WB_ADR_I == `PEM_OFS_DATA);

	// ----------------------------------------
	// read mux
	// ----------------------------------------
	// pins are seen through the synchroniser, two cycles after they move
	assign pin_level_word = {pin_sync_r, 8'h00};

	always_comb begin
		read_word = 32'h0000_0000;
		unique case (WB_ADR_I)
			`PEM_OFS_CTRL_L3: begin
				read_word[15:0] = ctrl_l3_r;
			end
			`PEM_OFS_CTRL_L4: begin
				read_word[15:0] = ctrl_l4_r;
			end
			`PEM_OFS_DIR: begin
				read_word[15:0] = dir_r;
			end
			`PEM_OFS_DATA: begin
				read_word[15:0] = data_r;
			end
			`PEM_OFS_PIN_LEVEL: begin
				read_word[15:0] = pin_level_word;
			end
			default: begin
				// unmapped offsets answer with zero
				read_word = 32'h0000_0000;
			end
		endcase
	end

	// ----------------------------------------
	// bus answer, next values
	// ----------------------------------------
	// ack blocks a second take while the master still holds its strobe
	always_comb begin
		ack_nxt = bus_req;
		rdata_nxt = rdata_r;
		if (rd_en) begin
			rdata_nxt = read_word;
		end
	end

	// ----------------------------------------
	// bus answer, flip-flops
	// ----------------------------------------
	// read data stays until the next read, so a slow master still finds it
	always_ff @(posedge CORE_CLK) begin
		if (!RST_B) begin
			ack_r <= 1'b0;
			rdata_r <= `PEM_RDATA_RST;
		end else begin
			ack_r <= ack_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign WB_ACK_O = ack_r;
	assign WB_DAT_O = rdata_r;

	// ----------------------------------------
	// register file, next values
	// ----------------------------------------
	always_comb begin
		ctrl_l3_nxt = ctrl_l3_r;
		ctrl_l4_nxt = ctrl_l4_r;
		dir_nxt = dir_r;
		data_nxt = data_r;
		if (wr_l3) begin
			ctrl_l3_nxt = (ctrl_l3_r & ~wr_lane_mask) | (wr_val & wr_lane_mask);
			ctrl_l3_nxt = ctrl_l3_nxt & `PEM_CTRL_L3_WMASK;
		end

		// pin 13 keeps bits 5:4 only, bit 6 is reserved
		if (wr_l4) begin
			ctrl_l4_nxt = (ctrl_l4_r & ~wr_lane_mask) | (wr_val & wr_lane_mask);
			ctrl_l4_nxt = ctrl_l4_nxt & `PEM_CTRL_L4_WMASK;
		end

		// only pins 8 to 15 live on this port, the low byte stays zero
		if (wr_dir) begin
			dir_nxt = (dir_r & ~wr_lane_mask) | (wr_val & wr_lane_mask);
			dir_nxt = dir_nxt & `PEM_PORT_WMASK;
		end

		if (wr_data) begin
			data_nxt = (data_r & ~wr_lane_mask) | (wr_val & wr_lane_mask);
			data_nxt = data_nxt & `PEM_PORT_WMASK;
		end
	end

	// ----------------------------------------
	// register file, flip-flops
	// ----------------------------------------
	always_ff @(posedge CORE_CLK) begin
		if (!RST_B) begin
			ctrl_l3_r <= `PEM_CTRL_L3_RST;
			ctrl_l4_r <= `PEM_CTRL_L4_RST;
			dir_r <= `PEM_DIR_RST;
			data_r <= `PEM_DATA_RST;
		end else begin
			ctrl_l3_r <= ctrl_l3_nxt;
			ctrl_l4_r <= ctrl_l4_nxt;
			dir_r <= dir_nxt;
			data_r <= data_nxt;
		end
	end

	// ----------------------------------------
	// pin level synchroniser, next values
	// ----------------------------------------
	// the first stage feeds the second stage and nothing else
	always_comb begin
		pin_meta_nxt = PORT_PIN_IN;
		pin_sync_nxt = pin_meta_r;
	end

	// ----------------------------------------
	// pin level synchroniser, flip-flops
	// ----------------------------------------
	always_ff @(posedge CORE_CLK) begin
		if (!RST_B) begin
			pin_meta_r <= `PEM_PIN_SYNC_RST;
			pin_sync_r <= `PEM_PIN_SYNC_RST;
		end else begin
			pin_meta_r <= pin_meta_nxt;
			pin_sync_r <= pin_sync_nxt;
		end
	end

	// ----------------------------------------
	// per-pin function select
	// ----------------------------------------
	// control words hold four pins each, one nibble per pin

	genvar gi;
	generate
		for (gi = 0; gi < `PEM_NUM_PINS; gi++) begin : g_pin
			// field position inside its control word
			localparam int FPOS = (gi % `PEM_PINS_PER_CTRL) * `PEM_FIELD_STRIDE;
			logic [2:0] mode;
			logic dir_bit;
			logic data_bit;

			if (gi < `PEM_PINS_PER_CTRL) begin : g_l3
				assign mode = ctrl_l3_r[FPOS +: `PEM_FIELD_WIDTH];
			end else begin : g_l4
				assign mode = ctrl_l4_r[FPOS +: `PEM_FIELD_WIDTH];
			end

			// direction and data bits sit at the pin's own number, 8 and up
			assign dir_bit = dir_r[`PEM_FIRST_PIN + gi];
			assign data_bit = data_r[`PEM_FIRST_PIN + gi];

			always_comb begin
				// codes other than the timer code fall back to GPIO
				pin_func[gi] = pem_pkg::PEM_FUNC_GPIO;
				if (gi == `PEM_PIN10_IDX) begin
					// no timer output exists here, any code stays GPIO
					pin_func[gi] = pem_pkg::PEM_FUNC_GPIO;
				end else if (gi == `PEM_PIN13_IDX) begin
					// only the two low bits choose this pin's function
					if (mode[1:0] == `PEM_MODE13_TIMER) begin
						pin_func[gi] = pem_pkg::PEM_FUNC_TIMER;
					end
				end else if (mode == `PEM_MODE_TIMER) begin
					pin_func[gi] = pem_pkg::PEM_FUNC_TIMER;
				end
			end

			always_comb begin
				// timer mode still needs the direction bit set to reach the pad
				pin_drive[gi].enable = dir_bit;
				if (pin_func[gi] == pem_pkg::PEM_FUNC_TIMER) begin
					pin_drive[gi].level = timer_vec[gi];
				end else begin
					pin_drive[gi].level = data_bit;
				end
			end

			assign pin_out_nxt[gi] = pin_drive[gi].level;
			assign pin_oe_nxt[gi] = pin_drive[gi].enable;
		end
	endgenerate

	// ----------------------------------------
	// pin drive flip-flops
	// ----------------------------------------
	// registered to keep the pad path glitch free; costs one cycle of PWM delay
	always_ff @(posedge CORE_CLK) begin
		if (!RST_B) begin
			pin_out_r <= `PEM_PIN_OUT_RST;
			pin_oe_r <= `PEM_PIN_OE_RST;
		end else begin
			pin_out_r <= pin_out_nxt;
			pin_oe_r <= pin_oe_nxt;
		end
	end

	assign PORT_PIN_OUT = pin_out_r;
	assign PORT_PIN_OE = pin_oe_r;

endmodule : pem_port_e_pwm_pin_function_select
`default_nettype wire

// file: verification/pem_pin_pads.sv
// Purpose: board side of port E pins 8 to 15
// Assumes: pin drive from the block is already registered
// Notes:   an undriven pin shows what the board puts on it, not the last driven level
`timescale 1ns/1ps
`default_nettype none
module pem_pin_pads (
	input wire logic [7:0] pad_out,
	input wire logic [7:0] pad_oe,
	input wire logic [7:0] board,
	output logic [7:0] pad
);
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			pad[i] = pad_oe[i] ? pad_out[i] : board[i];
		end
	end
endmodule : pem_pin_pads
`default_nettype wire

// file: verification/pem_pwm_chk.sv
// Purpose: port-level checks for the pin function select block
// Assumes: one clock, synchronous active-low reset
// Notes:   register state is hidden, so pin changes are tied to bus writes
`timescale 1ns/1ps
`default_nettype none
`include "pem_defines.svh"
module pem_pwm_chk (
	input wire logic CORE_CLK,
	input wire logic RST_B,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [7:0] WB_ADR_I,
	input wire logic [31:0] WB_DAT_O,
	input wire logic WB_ACK_O,
	input wire logic [7:0] PORT_PIN_OUT,
	input wire logic [7:0] PORT_PIN_OE
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RST_B);
	logic take;
	assign take = WB_CYC_I && WB_STB_I && !WB_ACK_O;
	a_reset_clear: assert property (disable iff (1'b0) !RST_B |=> PORT_PIN_OE == 8'h00 && !WB_ACK_O)
		else $error("outputs not cleared by reset");
	a_ack_after_take: assert property (take |=> WB_ACK_O)
		else $error("no ack after request");
	a_ack_one_cycle: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack longer than one cycle");
	a_ack_has_cause: assert property (WB_ACK_O |-> $past(take))
		else $error("ack without request");
	a_oe_from_dir: assert property ($changed(PORT_PIN_OE) |-> $past(take && WB_WE_I && WB_ADR_I == `PEM_OFS_DIR, 2))
		else $error("output enable moved without direction write");
	a_pin10_from_data: assert property ($changed(PORT_PIN_OUT[2]) |-> $past(take && WB_WE_I && WB_ADR_I == `PEM_OFS_DATA, 2))
		else $error("pin 10 level moved without data write");
	a_unmapped_zero: assert property (WB_ACK_O && !$past(WB_WE_I) && $past(WB_ADR_I) > 8'h10 |-> WB_DAT_O == 32'h0)
		else $error("unmapped read not zero");
	a_resv_l3_zero: assert property (WB_ACK_O && !$past(WB_WE_I) && $past(WB_ADR_I) == `PEM_OFS_CTRL_L3 |-> (WB_DAT_O & ~32'h7777) == 32'h0)
		else $error("reserved bits of L3 not zero");
	a_resv_l4_zero: assert property (WB_ACK_O && !$past(WB_WE_I) && $past(WB_ADR_I) == `PEM_OFS_CTRL_L4 |-> (WB_DAT_O & ~32'h7737) == 32'h0)
		else $error("reserved bits of L4 not zero");
endmodule : pem_pwm_chk
bind pem_port_e_pwm_pin_function_select pem_pwm_chk u_chk (.CORE_CLK, .RST_B, .WB_CYC_I, .WB_STB_I, .WB_WE_I,
	.WB_ADR_I, .WB_DAT_O, .WB_ACK_O, .PORT_PIN_OUT, .PORT_PIN_OE);
`default_nettype wire

// file: verification/pem_port_e_pwm_pin_function_select_tb_top.sv
// Purpose: random register and timer traffic against a shadow model
// Assumes: ack one cycle after the take edge, pins one cycle after cause
// Notes:   pin checks wait three cycles so latency never decides the outcome
`timescale 1ns/1ps
`default_nettype none
`include "pem_defines.svh"
module pem_port_e_pwm_pin_function_select_tb_top;
	logic clk = 0;
	logic rst_b = 0;
	logic cyc = 0;
	logic stb = 0;
	logic we = 0;
	logic [7:0] adr = 0;
	logic [3:0] sel = 0;
	logic [31:0] wd = 0;
	logic [31:0] rd;
	logic [31:0] dat_o;
	logic ack;
	logic [7:0] p_out;
	logic [7:0] p_oe;
	logic [7:0] pad;
	logic [7:0] board = 0;
	pem_pkg::pem_timer_s tm = '0;
	int bad_count = 0;
	int n_compared = 0;
	logic [15:0] rg [4] = '{default: 16'h0};
	logic [7:0] rd_ofs [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h02, 8'h40};
	always #4 clk = ~clk;
	pem_port_e_pwm_pin_function_select dut (.CORE_CLK(clk), .RST_B(rst_b), .WB_CYC_I(cyc), .WB_STB_I(stb),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wd), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
		.TIMER3_COMPARE_OUT_A(tm.t3_a), .TIMER3_COMPARE_OUT_B(tm.t3_b), .TIMER3_COMPARE_OUT_D(tm.t3_d),
		.TIMER4_COMPARE_OUT_A(tm.t4_a), .TIMER4_COMPARE_OUT_B(tm.t4_b), .TIMER4_COMPARE_OUT_C(tm.t4_c),
		.TIMER4_COMPARE_OUT_D(tm.t4_d), .PORT_PIN_IN(pad), .PORT_PIN_OUT(p_out), .PORT_PIN_OE(p_oe));
	pem_pin_pads u_pads (.pad_out(p_out), .pad_oe(p_oe), .board(board), .pad(pad));
	task automatic report_and_stop();
		if (bad_count == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop
	task automatic chk_read(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_read
	task automatic chk_pin(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_pin
	task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		sel <= s;
		wd <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n >= 50)
			bad_count++;
		rd = dat_o;
		cyc <= 0;
		stb <= 0;
	endtask : bus
	function automatic logic [15:0] wmask(input logic [7:0] a);
		case (a)
			`PEM_OFS_CTRL_L3: return `PEM_CTRL_L3_WMASK;
			`PEM_OFS_CTRL_L4: return `PEM_CTRL_L4_WMASK;
			`PEM_OFS_DIR, `PEM_OFS_DATA: return `PEM_PORT_WMASK;
			default: return 16'h0;
		endcase
	endfunction : wmask
	task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
		logic [15:0] m;
		m = {{8{s[1]}}, {8{s[0]}}} & wmask(a);
		bus(1'b1, a, s, d);
		rg[a[3:2]] = (rg[a[3:2]] & ~m) | (d[15:0] & m);
	endtask : wr
	task automatic rdchk(input logic [7:0] a);
		logic [31:0] e;
		bus(1'b0, a, 4'hf, 32'h0);
		e = (wmask(a) != 0) ? {16'h0, rg[a[3:2]]} : (a == `PEM_OFS_PIN_LEVEL) ? {16'h0, pad, 8'h0} : 32'h0;
		chk_read("read data", e, rd);
	endtask : rdchk
	// mode 001 picks the timer, pin 13 looks at two bits, pin 10 never leaves gpio
	function automatic logic [7:0] exp_pin();
		logic [2:0] f;
		logic [6:0] t;
		t = tm;
		for (int i = 0; i < 8; i++) begin
			f = 3'(rg[i / 4] >> (4 * (i % 4)));
			exp_pin[i] = ((i == 5) ? f[1:0] == 2'h1 : (i != 2 && f == 3'h1)) ? t[i - (i > 2)] : rg[3][8 + i];
		end
	endfunction : exp_pin
	initial begin
		void'($urandom(49));
		repeat (6) @(posedge clk);
		rst_b <= 1;
		wr(`PEM_OFS_CTRL_L3, 4'h3, 32'h1011);
		wr(`PEM_OFS_CTRL_L4, 4'h3, 32'h1111);
		wr(`PEM_OFS_DIR, 4'h3, 32'hfb00);
		for (int k = 0; k < 40; k++) begin
			for (int r = 0; r < 4 && k > 0; r++)
				wr(8'(4 * r), 4'($urandom), $urandom & ((r < 2 && k % 2 == 1) ? 32'h1111 : 32'hffff));
			repeat (8) begin
				tm <= 7'($urandom);
				board <= 8'($urandom);
				repeat (3) @(posedge clk);
				chk_pin("pin level", exp_pin(), p_out);
				chk_pin("pin enable", rg[2][15:8], p_oe);
			end
			wr(`PEM_OFS_PIN_LEVEL, 4'h3, $urandom);
			repeat (3) @(posedge clk);
			foreach (rd_ofs[j])
				rdchk(rd_ofs[j]);
		end
		report_and_stop();
	end
	initial begin
		repeat (40000) @(posedge clk);
		bad_count++;
		report_and_stop();
	end
endmodule : pem_port_e_pwm_pin_function_select_tb_top
`default_nettype wire
